// ### hdl/sadc_defines.vh
// Shared constants for the serial converter readout and power control block.
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH
`define SADC_CLK_MHZ 250
`define SADC_REINIT_MS 10
`define SADC_REINIT_CYC (`SADC_REINIT_MS * 1000 * `SADC_CLK_MHZ)
`define SADC_CONV_NS 400
`define SADC_CONV_CYC ((`SADC_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_RES_BITS 14
`define SADC_BIT_CNT_W 4
`define SADC_FIFO_DEPTH 16
`define SADC_FIFO_AW 4
`define SADC_PWR_OPER 2'h0
`define SADC_PWR_NAP 2'h1
`define SADC_PWR_SLEEP 2'h2
`define SADC_PULSES_W 2
`define SADC_TWO_PULSES 2'h2
`define SADC_ONE_PULSE 2'h1
`endif

// ### hdl/sadc_mem.v
// Small register-read memory holding buffered conversion results.
`timescale 1ns/1ns
module sadc_mem #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      // The read register reloads only on a pop, so a stalled output keeps its word.
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
    end
  end
endmodule

// ### hdl/sadc_fifo.v
// Result FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sadc_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire [AW:0] count = wr_ptr_reg - rd_ptr_reg;
  wire full = (count == DEPTH);
  wire empty = (count == {(AW+1){1'b0}});
  wire push = in_valid && !full;
  // Reading memory takes a cycle, so a word moves to the output stage only when it is free.
  wire pop = !empty && (!out_valid || out_ready);

  assign in_ready = !full;

  sadc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(push),
    .wr_addr(wr_ptr_reg[AW-1:0]),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_addr(rd_ptr_reg[AW-1:0]),
    .rd_data(out_data)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// ### hdl/sadc_core.v
// Converter control core: start, serial readout, nap and sleep sequencing, reinit.
`timescale 1ns/1ns
`include "sadc_defines.vh"
// Operation
// RQ1: Reset on power-up or supply dip.
// RQ2: Host waits reinit time before converting.
// RQ3: Early conversions flagged invalid.
// RQ4: Start falling edge begins timed conversion.
// RQ5: Host keeps start pulse wide enough.
// RQ6: Serial clock falling edge shifts MSB first.
// RQ7: Host supplies fast serial clock.
// RQ8: Host idles clock and gives two pulses.
// RQ9: Second start rising edge enters nap.
// RQ10: Nap ends on clock rise or pulses.
// RQ11: Two more pulses in nap enter sleep.
// RQ12: Single-ended: clock rise leaves sleep.
// RQ13: Host waits after sleep exit.
// RQ14: Differential: fifth pulse leaves sleep.
// RQ15: Clock activity blocks nap and sleep.
// RQ16: Single-ended also exits sleep by pulse.
// RQ17: Pulses cycle operational, nap, sleep.
// RQ18: Select input chooses signalling mode.
// RQ19: Single-ended uses positive pins only.
// RQ20: Differential drives and receives pairs.
// RQ21: Fourteen signed bits per conversion.
// RQ22: Host waits conversion time before clocking.
module sadc_core #(
  parameter REINIT_CYC = `SADC_REINIT_CYC
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire supply_ok,
  input wire conversion_start_n,
  input wire sck_p,
  input wire sck_n,
  input wire diff_sel,
  input wire [13:0] sample_value,
  output reg sdo_p,
  output reg sdo_n,
  output reg [1:0] power_state,
  output reg reinit_busy,
  output reg conv_busy,
  output reg result_invalid,
  output reg [13:0] result_data,
  output reg result_valid,
  input wire result_ready
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_SHIFT = 2'h2;

  reg [1:0] sup_sync_reg;
  reg [2:0] cnv_sync_reg;
  reg [2:0] sckp_sync_reg;
  reg [2:0] sckn_sync_reg;
  reg [1:0] sel_sync_reg;
  reg [31:0] reinit_cnt_reg;
  reg [15:0] conv_cnt_reg;
  reg [1:0] state_reg;
  reg [13:0] shift_reg;
  reg [`SADC_BIT_CNT_W-1:0] bit_cnt_reg;
  reg cur_invalid_reg;
  reg [`SADC_PULSES_W-1:0] pulses_reg;
  reg sck_seen_reg;
  reg fifo_in_valid_reg;
  reg [13:0] fifo_in_data_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [13:0] fifo_out_data;
  wire fifo_out_ready;

  // Only the second and third stages are read; the first stage is a pure synchroniser.
  wire supply_ok_s = sup_sync_reg[1];
  wire cnv_fall = cnv_sync_reg[2] && !cnv_sync_reg[1];
  wire cnv_rise = !cnv_sync_reg[2] && cnv_sync_reg[1];
  wire diff_mode = sel_sync_reg[1];
  // In single-ended mode the negative clock leg is pulled low, so only the positive leg counts.
  wire sck_now = diff_mode ? (sckp_sync_reg[1] && !sckn_sync_reg[1]) : sckp_sync_reg[1]; // RQ19 RQ20
  wire sck_prev = diff_mode ? (sckp_sync_reg[2] && !sckn_sync_reg[2]) : sckp_sync_reg[2];
  wire sck_rise = sck_now && !sck_prev;
  wire sck_fall = !sck_now && sck_prev;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sup_sync_reg <= 2'h0;
      cnv_sync_reg <= 3'h7;
      sckp_sync_reg <= 3'h0;
      sckn_sync_reg <= 3'h0;
      sel_sync_reg <= 2'h0;
    end else if (clk_en) begin
      sup_sync_reg <= {sup_sync_reg[0], supply_ok};
      cnv_sync_reg <= {cnv_sync_reg[1:0], conversion_start_n};
      sckp_sync_reg <= {sckp_sync_reg[1:0], sck_p};
      sckn_sync_reg <= {sckn_sync_reg[1:0], sck_n};
      sel_sync_reg <= {sel_sync_reg[0], diff_sel}; // RQ18
    end
  end

  // Supply dip holds the counter at zero; the reinit window restarts when supply returns.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reinit_cnt_reg <= 32'h0;
      reinit_busy <= 1'b1;
    end else if (clk_en) begin
      if (!supply_ok_s) begin
        reinit_cnt_reg <= 32'h0; // RQ1
        reinit_busy <= 1'b1;
      end else if (reinit_cnt_reg < REINIT_CYC) begin
        reinit_cnt_reg <= reinit_cnt_reg + 32'h1;
        reinit_busy <= 1'b1;
      end else begin
        reinit_busy <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n || !supply_ok_s) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 16'h0;
      shift_reg <= 14'h0;
      bit_cnt_reg <= {`SADC_BIT_CNT_W{1'b0}};
      cur_invalid_reg <= 1'b0;
      sdo_p <= 1'b0;
      sdo_n <= 1'b0;
      conv_busy <= 1'b0;
      fifo_in_valid_reg <= 1'b0;
      fifo_in_data_reg <= 14'h0;
    end else if (clk_en) begin
      if (fifo_in_ready) begin
        fifo_in_valid_reg <= 1'b0;
      end
      // A start edge samples only in the operational power state, but then even mid-readout, as the real converter restarts.
      if (cnv_fall && power_state == `SADC_PWR_OPER) begin
        state_reg <= ST_CONV; // RQ4
        conv_cnt_reg <= 16'h0;
        conv_busy <= 1'b1;
        cur_invalid_reg <= reinit_busy; // RQ3
      end else begin
        case (state_reg)
          ST_IDLE: begin
            conv_busy <= 1'b0;
          end
          ST_CONV: begin
            if (conv_cnt_reg == `SADC_CONV_CYC - 1) begin
              state_reg <= ST_SHIFT;
              conv_busy <= 1'b0;
              shift_reg <= sample_value; // RQ21
              bit_cnt_reg <= {`SADC_BIT_CNT_W{1'b0}};
              sdo_p <= sample_value[`SADC_RES_BITS-1];
              sdo_n <= diff_mode ? !sample_value[`SADC_RES_BITS-1] : 1'b0;
            end else begin
              conv_cnt_reg <= conv_cnt_reg + 16'h1;
            end
          end
          ST_SHIFT: begin
            if (sck_fall) begin
              if (bit_cnt_reg == `SADC_RES_BITS - 1) begin
                state_reg <= ST_IDLE;
                sdo_p <= 1'b0;
                sdo_n <= 1'b0;
                // A full FIFO drops the word rather than stall the link the host clocks.
                fifo_in_valid_reg <= fifo_in_ready;
                fifo_in_data_reg <= shift_reg;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                sdo_p <= shift_reg[`SADC_RES_BITS - 2 - bit_cnt_reg]; // RQ6
                sdo_n <= diff_mode ? !shift_reg[`SADC_RES_BITS - 2 - bit_cnt_reg] : 1'b0; // RQ20 RQ19
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Power sequencing counts start pulses by their rising edges with the serial clock idle.
  always @(posedge sys_clk) begin
    if (!rst_n || !supply_ok_s) begin
      power_state <= `SADC_PWR_OPER;
      pulses_reg <= {`SADC_PULSES_W{1'b0}};
      sck_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (sck_rise || sck_fall) begin
        sck_seen_reg <= 1'b1;
      end
      if (sck_rise && (power_state == `SADC_PWR_NAP ||
          (power_state == `SADC_PWR_SLEEP && !diff_mode))) begin
        power_state <= `SADC_PWR_OPER; // RQ10 RQ12
        pulses_reg <= {`SADC_PULSES_W{1'b0}};
      end else if (cnv_rise) begin
        // A clock edge landing with the start rise must not be lost, so it counts for the next gap.
        sck_seen_reg <= sck_rise || sck_fall;
        if (sck_seen_reg && power_state == `SADC_PWR_OPER) begin
          pulses_reg <= `SADC_ONE_PULSE; // RQ15
        end else if (power_state == `SADC_PWR_SLEEP) begin
          power_state <= `SADC_PWR_OPER; // RQ14 RQ16 RQ17
          pulses_reg <= {`SADC_PULSES_W{1'b0}};
        end else if (pulses_reg == `SADC_ONE_PULSE) begin
          power_state <= (power_state == `SADC_PWR_OPER) ?
            `SADC_PWR_NAP : `SADC_PWR_SLEEP; // RQ9 RQ11
          pulses_reg <= {`SADC_PULSES_W{1'b0}};
        end else begin
          pulses_reg <= `SADC_ONE_PULSE;
        end
      end
    end
  end

  sadc_fifo #(.WIDTH(`SADC_RES_BITS), .DEPTH(`SADC_FIFO_DEPTH), .AW(`SADC_FIFO_AW)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid_reg),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = !result_valid || result_ready;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result_data <= 14'h0;
      result_invalid <= 1'b0;
    end else if (clk_en) begin
      if (fifo_out_valid && fifo_out_ready) begin
        result_valid <= 1'b1;
        result_data <= fifo_out_data;
      end else if (result_ready) begin
        result_valid <= 1'b0;
      end
      if (state_reg == ST_CONV) begin
        result_invalid <= cur_invalid_reg;
      end
    end
  end
endmodule

// ### bench/sadc_core_monitor.sv
// Concurrent checks on the ports of the converter control core.
`timescale 1ns/1ns
`include "sadc_defines.vh"
module sadc_core_monitor #(
  parameter REINIT_CYC = 200
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire supply_ok,
  input wire conversion_start_n,
  input wire sck_p,
  input wire sck_n,
  input wire diff_sel,
  input wire [13:0] sample_value,
  input wire sdo_p,
  input wire sdo_n,
  input wire [1:0] power_state,
  input wire reinit_busy,
  input wire conv_busy,
  input wire result_invalid,
  input wire [13:0] result_data,
  input wire result_valid,
  input wire result_ready
);
  reg [6:0] busy_cnt_reg;
  reg [31:0] init_cnt_reg;
  // Synchroniser latency on the supply pin makes the window a few cycles wide.
  always @(posedge sys_clk) begin
    busy_cnt_reg <= conv_busy ? busy_cnt_reg + 7'h01 : 7'h00;
    init_cnt_reg <= (!rst_n || !supply_ok || !reinit_busy) ? 32'h0 : init_cnt_reg + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sdo_single_a: assert property ((!diff_sel) [*4] |-> !sdo_n)
    else $error("negative data leg driven in single-ended mode");
  sdo_diff_a: assert property (diff_sel [*4] ##0 $fell(conv_busy) |-> sdo_n == !sdo_p)
    else $error("data pair not complementary");
  conv_trig_a: assert property ($fell(conversion_start_n) && power_state == `SADC_PWR_OPER
    && !conv_busy |-> ##[2:6] conv_busy)
    else $error("start edge did not begin a conversion");
  conv_len_a: assert property ($fell(conv_busy) |-> busy_cnt_reg >= 7'h63 && busy_cnt_reg <= 7'h65)
    else $error("conversion time wrong");
  start_block_a: assert property (power_state != `SADC_PWR_OPER |=> !$rose(conv_busy))
    else $error("conversion began in a low power state");
  msb_first_a: assert property ($fell(conv_busy) |-> sdo_p == sample_value[13])
    else $error("first serial bit is not the sign bit");
  reinit_len_a: assert property ($fell(reinit_busy) |->
    init_cnt_reg >= REINIT_CYC - 2 && init_cnt_reg <= REINIT_CYC + 4)
    else $error("reinitialisation window wrong length");
  state_order_a: assert property ($changed(power_state) && power_state != `SADC_PWR_OPER
    |-> power_state == $past(power_state) + 2'h1)
    else $error("power state skipped a step");
  state_hold_a: assert property ((power_state != `SADC_PWR_OPER && $stable(sck_p)
    && $stable(conversion_start_n) && $stable(supply_ok)) [*6] |=> $stable(power_state))
    else $error("power state moved without pin activity");
  fifo_hold_a: assert property (result_valid && !result_ready |=>
    result_valid && $stable(result_data))
    else $error("result dropped while stalled");
  cover property (power_state == `SADC_PWR_SLEEP);
  cover property (result_valid && !result_ready);
  cover property ($fell(reinit_busy));
endmodule
bind sadc_core sadc_core_monitor #(.REINIT_CYC(REINIT_CYC)) i_mon (.sys_clk, .rst_n, .clk_en,
  .supply_ok, .conversion_start_n, .sck_p, .sck_n, .diff_sel, .sample_value, .sdo_p, .sdo_n,
  .power_state, .reinit_busy, .conv_busy, .result_invalid, .result_data, .result_valid,
  .result_ready);

// ### bench/sadc_host_model.sv
// Host model that drives start pulses and the serial clock.
`timescale 1ns/1ns
module sadc_host_model (
  input wire sys_clk,
  input wire diff_sel,
  input wire sdo_p,
  output reg conversion_start_n,
  output reg sck_p,
  output wire sck_n
);
  // The clock rests low outside frames; the negative leg is grounded when unused.
  assign sck_n = diff_sel ? !sck_p : 1'b0;
  initial begin
    conversion_start_n = 1'b1;
    sck_p = 1'b0;
  end
  task pulse;
    begin
      @(negedge sys_clk) conversion_start_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      conversion_start_n = 1'b1;
      repeat (120) @(negedge sys_clk);
    end
  endtask
  task wake;
    begin
      sck_p = 1'b1;
      repeat (10) @(negedge sys_clk);
      sck_p = 1'b0;
      repeat (10) @(negedge sys_clk);
    end
  endtask
  // Each bit is taken before the falling edge that shifts the next one out.
  task readout(input integer gap, output logic [13:0] word);
    integer i;
    begin
      repeat (gap) @(negedge sys_clk);
      for (i = 13; i >= 0; i = i - 1) begin
        sck_p = 1'b1;
        repeat (10) @(negedge sys_clk);
        word[i] = sdo_p;
        sck_p = 1'b0;
        repeat (10) @(negedge sys_clk);
      end
    end
  endtask
endmodule

// ### bench/sar_adc_serial_readout_power_modes_tb_top.sv
// Self-checking bench for the converter control core.
`timescale 1ns/1ns
`include "sadc_defines.vh"
`define SADC_CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, s); end end
module sar_adc_serial_readout_power_modes_tb_top;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg supply_ok = 1'b1;
  reg diff_sel = 1'b0;
  reg result_ready = 1'b1;
  reg [13:0] sample_value = 14'h0000;
  wire conversion_start_n, sck_p, sck_n, sdo_p, sdo_n, reinit_busy, conv_busy;
  wire result_invalid, result_valid;
  wire [1:0] power_state;
  wire [13:0] result_data;
  logic [13:0] exp_q[$];
  logic [13:0] word, head;
  integer bad_count = 0, tests_run = 0, cycles = 0, i, k, m;
  sadc_core #(.REINIT_CYC(200)) i_dut (.sys_clk, .rst_n, .clk_en(1'b1), .supply_ok,
    .conversion_start_n, .sck_p, .sck_n, .diff_sel, .sample_value, .sdo_p, .sdo_n,
    .power_state, .reinit_busy, .conv_busy, .result_invalid, .result_data, .result_valid,
    .result_ready);
  sadc_host_model i_host (.sys_clk, .diff_sel, .sdo_p, .conversion_start_n, .sck_p, .sck_n);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task conclude;
    begin
      if (bad_count == 0 && tests_run > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end else if (rst_n && result_valid === 1'b1 && result_ready) begin
      `SADC_CHK("word_expected", 1'b1, exp_q.size() > 0)
      head = exp_q.pop_front();
      `SADC_CHK("result_data", head, result_data)
    end
  end
  task wait_init;
    begin
      for (k = 0; k < 400 && reinit_busy !== 1'b0; k++) @(negedge sys_clk);
      `SADC_CHK("reinit_busy", 1'b0, reinit_busy)
    end
  endtask
  // The expectation is noted before readout, since the word can surface first.
  task convert(input integer keep);
    begin
      sample_value = 14'($urandom);
      diff_sel = 1'($urandom);
      if (keep) exp_q.push_back(sample_value);
      i_host.pulse();
      i_host.readout($urandom % 41, word);
      `SADC_CHK("serial_word", sample_value, word)
    end
  endtask
  task power(input [1:0] st);
    `SADC_CHK("power_state", st, power_state)
  endtask
  initial begin
    k = $urandom(41256);
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    `SADC_CHK("reinit_busy", 1'b1, reinit_busy)
    i_host.pulse();
    `SADC_CHK("result_invalid", 1'b1, result_invalid)
    wait_init();
    // Clock activity first, so the pulse left over from the reinit test is not counted.
    i_host.wake();
    for (m = 0; m < 2; m++) begin
      diff_sel = m[0];
      repeat (2) i_host.pulse();
      power(`SADC_PWR_NAP);
      i_host.wake();
      power(`SADC_PWR_OPER);
      repeat (4) i_host.pulse();
      power(`SADC_PWR_SLEEP);
      i_host.pulse();
      power(`SADC_PWR_OPER);
      repeat (4) i_host.pulse();
      i_host.wake();
      power(m ? `SADC_PWR_SLEEP : `SADC_PWR_OPER);
      if (m) i_host.pulse();
    end
    repeat (2) i_host.pulse();
    supply_ok = 1'b0;
    repeat (5) @(negedge sys_clk);
    `SADC_CHK("dip_state", `SADC_PWR_OPER, power_state)
    `SADC_CHK("dip_reinit", 1'b1, reinit_busy)
    supply_ok = 1'b1;
    wait_init();
    repeat (2) convert(1);
    `SADC_CHK("result_invalid", 1'b0, result_invalid)
    power(`SADC_PWR_OPER);
    result_ready = 1'b0;
    // The FIFO output stage and the result register hold two words beyond the 16 buffered.
    for (i = 0; i < 20; i++) convert(i < 18);
    for (i = 0; i < 60; i++) @(negedge sys_clk) result_ready = 1'($urandom);
    result_ready = 1'b1;
    repeat (40) @(negedge sys_clk);
    `SADC_CHK("drained", 0, exp_q.size())
    conclude();
  end
endmodule
